/* rtl/mosc_top.sv */
// Purpose: Output decision of a monitoring relay with settling delay and speed scaling
// Assumes: Monitoring inputs are synchronous levels; keys and menu exit are one-cycle pulses
// Notes: Registers over classic bus, one-cycle answer
//
// Notes on behaviour
// - Energized-normal: relay on with supply present and no fault.
// - Energized-normal: relay released on fault, same as supply loss.
// - Energized-normal: semiconductor output goes high-impedance on fault.
// - Energize-on-fault: relay on only while a fault is present.
// - Energize-on-fault: semiconductor output drives supply level on fault.
// - Overshoot selector position selects drainage control.
// - Drainage: contact closes after upper overshoot plus tripping delay.
// - Drainage: released only on lower undershoot; held between thresholds.
// - Undershoot position selects inflow control; relay on with supply.
// - Inflow: relay released on upper overshoot.
// - Inflow: re-energized only on lower undershoot; held between thresholds.
// - Normal position only after values stable for the whole settling time.
// - Violation during settling restarts it instead of signalling fault.
// - Settling starts when supply returns.
// - Manual reset acknowledge starts settling, then acts as power-on.
// - Process image start command starts settling.
// - Settling start triggers changeable only over the link, not keys.
// - Leaving the settings menu restarts settling.
// - Enabled phase-loss supervision forces fault state at once.
// - Phase-loss reaction ignores all delay timers.
// - Encoder pulses per one-second gate, times 60 and divided by pulses-per-revolution, give rpm.
// - Manual reset response latches the trip until reset.
`timescale 1ns/1ps
`default_nettype none
`include "mosc_map.svh"
module mosc_top
  import mosc_pkg::*;
#(
  parameter int unsigned MS_CYC = `MOSC_MS_CYC,
  parameter int unsigned GATE_CYC = `MOSC_GATE_CYC
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic supply_ok_i,
  input wire logic fault_i,
  input wire logic upper_over_i,
  input wire logic lower_under_i,
  input wire logic phase_loss_i,
  input wire logic manual_reset_i,
  input wire logic menu_exit_i,
  input wire logic [1:0] mode_sel_i,
  input wire logic key_settle_we_i,
  input wire logic [15:0] key_settle_ms_i,
  input wire logic enc_pulse_i,
  output logic relay_o,
  output logic semi_q_o,
  output logic semi_q_oe_o,
  output logic settling_o,
  output logic [15:0] rpm_o
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic ack_r;
  logic [31:0] dat_r;
  logic [2:0] ctrl_r;
  logic [15:0] settle_ms_r;
  logic [1:0] trig_r;
  logic [15:0] ppr_r;
  logic [15:0] trip_ms_r;
  logic princ_no_r;
  mosc_mode_type mode_r;
  mosc_mode_type mode_nxt;
  mosc_state_type st_r;
  mosc_state_type st_nxt;
  logic fault_lat_r;
  logic lvl_r;
  logic upper_prev_r;
  logic relay_r;
  logic relay_nxt;
  logic semi_r;
  logic semi_nxt;
  logic settle_load;
  logic [15:0] rpm_w;

  mosc_tmr_if settle_t ();
  mosc_tmr_if trip_t ();

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire req = cyc_i & stb_i & ~ack_r;
  wire wr = req & we_i;
  wire [7:0] badr = {adr_i[7:2], 2'b00};
  wire hit_ctrl = (badr == `MOSC_OFF_CTRL);
  wire hit_settle = (badr == `MOSC_OFF_SETTLE);
  wire hit_trig = (badr == `MOSC_OFF_TRIG);
  wire hit_ppr = (badr == `MOSC_OFF_PPR);
  wire hit_status = (badr == `MOSC_OFF_STATUS);
  wire hit_speed = (badr == `MOSC_OFF_SPEED);
  wire hit_cmd = (badr == `MOSC_OFF_CMD);
  wire hit_trip = (badr == `MOSC_OFF_TRIP);
  wire cmd_start = wr & hit_cmd & sel_i[0] & dat_i[`MOSC_CMD_START];
  wire cmd_mrst = wr & hit_cmd & sel_i[0] & dat_i[`MOSC_CMD_MRST];

  // ----------------------------------------
  // Derived conditions
  // ----------------------------------------
  wire man_resp = ctrl_r[`MOSC_CTRL_MAN_RESP];
  wire ph_trip = ctrl_r[`MOSC_CTRL_PHASE_EN] & phase_loss_i;
  wire mreset = manual_reset_i | cmd_mrst;
  wire in_run = (st_r == ST_RUN);
  wire in_settle = (st_r == ST_SETTLE);
  wire mrst_start = mreset & fault_lat_r & trig_r[`MOSC_TRIG_MRST];
  wire start_req = mrst_start | cmd_start | menu_exit_i;
  wire fault_run = in_run & (fault_i | fault_lat_r);
  wire fault_state = ph_trip | fault_run;
  wire normal_pos = in_run & ~fault_run & ~ph_trip;
  wire upper_rise = upper_over_i & ~upper_prev_r;
  wire lvl_set = (mode_r == MODE_DRAIN) ? (trip_t.done & upper_over_i) : upper_over_i;

  wire [31:0] status_w = {26'h0000000, ph_trip, lvl_r, in_settle, fault_lat_r,
                          semi_r, relay_r};
  wire [31:0] rd_data = hit_ctrl ? {29'h00000000, ctrl_r} :
                        hit_settle ? {16'h0000, settle_ms_r} :
                        hit_trig ? {30'h00000000, trig_r} :
                        hit_ppr ? {16'h0000, ppr_r} :
                        hit_status ? status_w :
                        hit_speed ? {16'h0000, rpm_w} :
                        hit_trip ? {16'h0000, trip_ms_r} :
                        32'h00000000;

  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign relay_o = relay_r;
  assign semi_q_o = semi_r;
  assign semi_q_oe_o = semi_r;
  assign settling_o = in_settle;
  assign rpm_o = rpm_w;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // Unmapped words read zero, drop writes and still answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end
    else
    begin
      ack_r <= req;
      dat_r <= req ? rd_data : dat_r;
    end
  end

  // Keys only reach the settling time; trigger choice has no key path
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= `MOSC_RST_CTRL;
      settle_ms_r <= `MOSC_RST_SETTLE;
      trig_r <= `MOSC_RST_TRIG;
      ppr_r <= `MOSC_RST_PPR;
      trip_ms_r <= `MOSC_RST_TRIP;
    end
    else
    begin
      if (wr & hit_ctrl & sel_i[0])
        ctrl_r <= dat_i[2:0];
      if (wr & hit_trig & sel_i[0])
        trig_r <= dat_i[1:0];
      if (key_settle_we_i)
        settle_ms_r <= key_settle_ms_i;
      if (wr & hit_settle & sel_i[0])
        settle_ms_r[7:0] <= dat_i[7:0];
      if (wr & hit_settle & sel_i[1])
        settle_ms_r[15:8] <= dat_i[15:8];
      if (wr & hit_ppr & sel_i[0])
        ppr_r[7:0] <= dat_i[7:0];
      if (wr & hit_ppr & sel_i[1])
        ppr_r[15:8] <= dat_i[15:8];
      if (wr & hit_trip & sel_i[0])
        trip_ms_r[7:0] <= dat_i[7:0];
      if (wr & hit_trip & sel_i[1])
        trip_ms_r[15:8] <= dat_i[15:8];
    end
  end

  // ----------------------------------------
  // Configuration sampling
  // ----------------------------------------
  // Selector is a rotary switch; registering it avoids a torn decode
  always_comb
  begin
    case (mode_sel_i)
      `MOSC_SEL_DRAIN: mode_nxt = MODE_DRAIN;
      `MOSC_SEL_INFLOW: mode_nxt = MODE_INFLOW;
      default: mode_nxt = MODE_FAULT;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      princ_no_r <= 1'b0;
      mode_r <= MODE_FAULT;
    end
    else
    begin
      princ_no_r <= ctrl_r[`MOSC_CTRL_PRINC_NO];
      mode_r <= mode_nxt;
    end
  end

  // ----------------------------------------
  // Settling sequence
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    settle_load = 1'b0;
    case (st_r)
      ST_OFF:
      begin
        if (supply_ok_i & trig_r[`MOSC_TRIG_POR])
        begin
          st_nxt = ST_SETTLE;
          settle_load = 1'b1;
        end
        else if (supply_ok_i)
          st_nxt = ST_RUN;
      end
      ST_SETTLE:
      begin
        if (~supply_ok_i)
          st_nxt = ST_OFF;
        else if (fault_i | start_req)
          settle_load = 1'b1;
        else if (settle_t.done)
          st_nxt = ST_RUN;
      end
      ST_RUN:
      begin
        if (~supply_ok_i)
          st_nxt = ST_OFF;
        else if (start_req)
        begin
          st_nxt = ST_SETTLE;
          settle_load = 1'b1;
        end
      end
      default: st_nxt = ST_OFF;
    endcase
  end

  assign settle_t.load = settle_load;
  assign settle_t.dur_ms = settle_ms_r;
  assign trip_t.load = upper_rise & (mode_r == MODE_DRAIN);
  assign trip_t.dur_ms = trip_ms_r;

  // ----------------------------------------
  // Fault latch and level state
  // ----------------------------------------
  // A new trip in the reset cycle wins over the acknowledge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= ST_OFF;
      fault_lat_r <= 1'b0;
      lvl_r <= 1'b0;
      upper_prev_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      upper_prev_r <= upper_over_i;
      if (man_resp & in_run & fault_i)
        fault_lat_r <= 1'b1;
      else if (mreset | ~man_resp)
        fault_lat_r <= 1'b0;
      if (lvl_set)
        lvl_r <= 1'b1;
      else if (lower_under_i)
        lvl_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Output decision
  // ----------------------------------------
  // Phase loss bypasses settling and tripping delays in every mode
  always_comb
  begin
    relay_nxt = 1'b0;
    semi_nxt = 1'b0;
    case (mode_r)
      MODE_DRAIN:
      begin
        relay_nxt = supply_ok_i & in_run & lvl_r & ~ph_trip;
        semi_nxt = relay_nxt;
      end
      MODE_INFLOW:
      begin
        relay_nxt = supply_ok_i & in_run & ~lvl_r & ~ph_trip;
        semi_nxt = relay_nxt;
      end
      MODE_FAULT:
      begin
        if (princ_no_r)
        begin
          relay_nxt = supply_ok_i & fault_state;
          semi_nxt = supply_ok_i & fault_state;
        end
        else
        begin
          relay_nxt = supply_ok_i & normal_pos;
          semi_nxt = supply_ok_i & normal_pos;
        end
      end
      default:
      begin
        relay_nxt = 1'b0;
        semi_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      relay_r <= 1'b0;
      semi_r <= 1'b0;
    end
    else
    begin
      relay_r <= relay_nxt;
      semi_r <= semi_nxt;
    end
  end

  // ----------------------------------------
  // Timers and speed scaling
  // ----------------------------------------
  mosc_timer #(
    .MS_CYC(MS_CYC)
  ) u_settle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .t(settle_t)
  );

  mosc_timer #(
    .MS_CYC(MS_CYC)
  ) u_trip (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .t(trip_t)
  );

  // Speed refreshes once per gate, so a new scaling shows one gate later
  mosc_speed #(
    .GATE_CYC(GATE_CYC)
  ) u_speed (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pulse_i(enc_pulse_i),
    .ppr_i(ppr_r),
    .rpm_o(rpm_w)
  );
endmodule
`default_nettype wire

/* include/mosc_map.svh */
// Purpose: Offsets, field positions, reset values and timing of the output switching control
// Assumes: 32-bit classic bus, byte addresses, one register per aligned word
// Notes: Definitions only
`ifndef MOSC_MAP_SVH
`define MOSC_MAP_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define MOSC_CLK_HZ 40000000
`define MOSC_MS_PER_S 1000
`define MOSC_MS_CYC (`MOSC_CLK_HZ / `MOSC_MS_PER_S)
`define MOSC_GATE_S 1
`define MOSC_GATE_CYC (`MOSC_CLK_HZ * `MOSC_GATE_S)
`define MOSC_S_PER_MIN 32'h0000003c
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MOSC_OFF_CTRL 8'h00
`define MOSC_OFF_SETTLE 8'h04
`define MOSC_OFF_TRIG 8'h08
`define MOSC_OFF_PPR 8'h0c
`define MOSC_OFF_STATUS 8'h10
`define MOSC_OFF_SPEED 8'h14
`define MOSC_OFF_CMD 8'h18
`define MOSC_OFF_TRIP 8'h1c
// ----------------------------------------
// Fields
// ----------------------------------------
`define MOSC_CTRL_PRINC_NO 0
`define MOSC_CTRL_PHASE_EN 1
`define MOSC_CTRL_MAN_RESP 2
`define MOSC_TRIG_POR 0
`define MOSC_TRIG_MRST 1
`define MOSC_CMD_START 0
`define MOSC_CMD_MRST 1
`define MOSC_SEL_DRAIN 2'h1
`define MOSC_SEL_INFLOW 2'h2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define MOSC_RST_CTRL 3'h0
`define MOSC_RST_SETTLE 16'h0000
`define MOSC_RST_TRIG 2'h3
`define MOSC_RST_PPR 16'h0001
`define MOSC_RST_TRIP 16'h0000
`endif

/* include/mosc_pkg.sv */
// Purpose: Types of the output switching control
// Assumes: Nothing beyond the map header
// Notes: Enumerations only
`default_nettype none
package mosc_pkg;
  typedef enum logic [1:0] {ST_OFF, ST_SETTLE, ST_RUN} mosc_state_type;
  typedef enum logic [1:0] {MODE_FAULT, MODE_DRAIN, MODE_INFLOW} mosc_mode_type;
endpackage
`default_nettype wire

/* include/mosc_tmr_if.sv */
// Purpose: Carrier between the control and a millisecond delay timer
// Assumes: One clock
// Notes: Load restarts a running count
`timescale 1ns/1ps
`default_nettype none
interface mosc_tmr_if;
  logic load;
  logic [15:0] dur_ms;
  logic busy;
  logic done;
  modport ctl (output load, output dur_ms, input busy, input done);
  modport tmr (input load, input dur_ms, output busy, output done);
endinterface
`default_nettype wire

/* rtl/mosc_timer.sv */
// Purpose: Millisecond countdown with reload
// Assumes: Duration taken at load
// Notes: Done is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
`include "mosc_map.svh"
module mosc_timer #(
  parameter int unsigned MS_CYC = `MOSC_MS_CYC
)(
  input wire logic clk_i,
  input wire logic rst_i,
  mosc_tmr_if.tmr t
);
  logic [31:0] pre_r;
  logic [15:0] ms_r;
  logic busy_r;
  logic done_r;
  wire tick = (pre_r == 32'(MS_CYC - 1));
  wire at_zero = (ms_r == 16'h0000);

  assign t.busy = busy_r;
  assign t.done = done_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_r <= 32'h00000000;
      ms_r <= 16'h0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= busy_r & at_zero & ~t.load;
      if (t.load)
      begin
        busy_r <= 1'b1;
        ms_r <= t.dur_ms;
        pre_r <= 32'h00000000;
      end
      else if (busy_r & at_zero)
        busy_r <= 1'b0;
      else if (busy_r)
      begin
        pre_r <= tick ? 32'h00000000 : pre_r + 32'h00000001;
        ms_r <= tick ? ms_r - 16'h0001 : ms_r;
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/mosc_speed.sv */
// Purpose: Pulse count per gate scaled to revolutions per minute
// Assumes: Encoder pulse is synchronous to the clock
// Notes: Zero scaling reads as zero speed
`timescale 1ns/1ps
`default_nettype none
`include "mosc_map.svh"
module mosc_speed #(
  parameter int unsigned GATE_CYC = `MOSC_GATE_CYC
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pulse_i,
  input wire logic [15:0] ppr_i,
  output logic [15:0] rpm_o
);
  logic pulse_prev_r;
  logic [31:0] gate_r;
  logic [31:0] cnt_r;
  logic [31:0] quo_r;
  logic [31:0] rem_r;
  logic [15:0] den_r;
  logic [5:0] step_r;
  logic [15:0] rpm_r;
  wire gate_end = (gate_r == 32'(GATE_CYC - 1));
  wire edge_seen = pulse_i & ~pulse_prev_r;
  wire [31:0] rem_sh = {rem_r[30:0], quo_r[31]};
  wire ge = (rem_sh >= {16'h0000, den_r});
  wire quo_big = (quo_r[31:16] != 16'h0000);

  assign rpm_o = rpm_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pulse_prev_r <= 1'b0;
      gate_r <= 32'h00000000;
      cnt_r <= 32'h00000000;
      quo_r <= 32'h00000000;
      rem_r <= 32'h00000000;
      den_r <= 16'h0000;
      step_r <= 6'h00;
      rpm_r <= 16'h0000;
    end
    else
    begin
      pulse_prev_r <= pulse_i;
      gate_r <= gate_end ? 32'h00000000 : gate_r + 32'h00000001;
      cnt_r <= gate_end ? 32'(edge_seen) : cnt_r + 32'(edge_seen);
      if (gate_end)
      begin
        quo_r <= cnt_r * `MOSC_S_PER_MIN;
        rem_r <= 32'h00000000;
        den_r <= ppr_i;
        step_r <= 6'h20;
      end
      else if (step_r != 6'h00)
      begin
        rem_r <= ge ? rem_sh - {16'h0000, den_r} : rem_sh;
        quo_r <= {quo_r[30:0], ge};
        step_r <= step_r - 6'h01;
      end
      else if (den_r == 16'h0000)
        rpm_r <= 16'h0000;
      else
        rpm_r <= quo_big ? 16'hffff : quo_r[15:0];
    end
  end
endmodule
`default_nettype wire

/* bench/mosc_load.sv */
// Purpose: Contactor and semiconductor load on the far side of the outputs
// Assumes: One clock; the Q line has a pull-down
// Notes: The link master side is played by the bench's bus tasks
`timescale 1ns/1ps
`default_nettype none
module mosc_load (
  input wire logic clk_i,
  input wire logic relay_i,
  input wire logic q_i,
  input wire logic q_oe_i,
  output logic coil_o,
  output logic q_pin_o
);
  // Undriven Q reads the pull-down level, never the last driven value
  assign q_pin_o = q_oe_i ? q_i : 1'b0;
  // Contactor picks up one cycle after its coil
  always_ff @(posedge clk_i) coil_o <= relay_i;
endmodule
`default_nettype wire

/* bench/mosc_top_asserts.sv */
// Purpose: Port-level checks of the output switching control
// Assumes: One clock, synchronous active-high reset
// Notes: Output latency of two cycles is allowed for in the repetitions
`timescale 1ns/1ps
`default_nettype none
module mosc_top_asserts #(
  parameter int unsigned MS_CYC = 4,
  parameter int unsigned GATE_CYC = 200
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic supply_ok_i,
  input wire logic fault_i,
  input wire logic lower_under_i,
  input wire logic upper_over_i,
  input wire logic phase_loss_i,
  input wire logic manual_reset_i,
  input wire logic menu_exit_i,
  input wire logic [1:0] mode_sel_i,
  input wire logic relay_o,
  input wire logic semi_q_o,
  input wire logic semi_q_oe_o,
  input wire logic settling_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_cmd_start;
    s_take ##0 (we_i && adr_i == 8'h18 && sel_i[0] && dat_i[0] && supply_ok_i);
  endsequence
  // Anything that may restart settling is excluded while the level is held
  sequence s_drain_quiet;
    mode_sel_i == 2'h1 && supply_ok_i && !phase_loss_i && !lower_under_i && !fault_i
      && !menu_exit_i && !manual_reset_i && !cyc_i;
  endsequence
  property p_ack_resp;
    s_take |=> ack_o;
  endproperty
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  property p_semi_oe;
    semi_q_oe_o == semi_q_o;
  endproperty
  property p_supply_off;
    !supply_ok_i [*3] |-> !relay_o && !semi_q_oe_o;
  endproperty
  property p_settle_hold;
    (settling_o && !phase_loss_i) [*4] |-> !relay_o;
  endproperty
  property p_restart;
    settling_o && fault_i && supply_ok_i ##1 supply_ok_i |-> settling_o;
  endproperty
  property p_menu;
    menu_exit_i && supply_ok_i |-> ##[1:3] settling_o;
  endproperty
  property p_cmd;
    s_cmd_start |-> ##[1:3] settling_o;
  endproperty
  property p_inflow;
    (mode_sel_i == 2'h2 && upper_over_i) [*4] |-> !relay_o;
  endproperty
  property p_drain_hold;
    s_drain_quiet [*3] ##0 relay_o |=> relay_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  a_semi_oe: assert property (p_semi_oe)
    else $error("semiconductor enable differs from level");
  a_supply_off: assert property (p_supply_off)
    else $error("outputs on without supply");
  a_settle_hold: assert property (p_settle_hold)
    else $error("relay on while settling");
  a_restart: assert property (p_restart)
    else $error("violation ended settling");
  a_menu: assert property (p_menu)
    else $error("menu exit did not restart settling");
  a_cmd: assert property (p_cmd)
    else $error("start command did not start settling");
  a_inflow: assert property (p_inflow)
    else $error("inflow relay on above upper level");
  a_drain_hold: assert property (p_drain_hold)
    else $error("drainage relay dropped between levels");
endmodule
bind mosc_top mosc_top_asserts #(.MS_CYC(MS_CYC), .GATE_CYC(GATE_CYC)) asrt_u (
  .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i), .sel_i(sel_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .supply_ok_i(supply_ok_i),
  .fault_i(fault_i), .lower_under_i(lower_under_i), .upper_over_i(upper_over_i),
  .phase_loss_i(phase_loss_i), .manual_reset_i(manual_reset_i),
  .menu_exit_i(menu_exit_i), .mode_sel_i(mode_sel_i), .relay_o(relay_o),
  .semi_q_o(semi_q_o), .semi_q_oe_o(semi_q_oe_o), .settling_o(settling_o)
);
`default_nettype wire

/* bench/mosc_top_bench.sv */
// Purpose: Self-checking bench of the output switching control
// Assumes: Short millisecond and gate counts (4 and 200 cycles)
// Notes: Row fields are mode, principle, supply, fault, upper, lower, relay, wait
`timescale 1ns/1ps
`default_nettype none
module mosc_top_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [3:0] sel_i = 4'h0;
  logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, supply_ok_i = 1'b0, fault_i = 1'b0;
  logic upper_over_i = 1'b0, lower_under_i = 1'b0, phase_loss_i = 1'b0;
  logic manual_reset_i = 1'b0, menu_exit_i = 1'b0, key_settle_we_i = 1'b0;
  logic [1:0] mode_sel_i = 2'h0;
  logic [15:0] key_settle_ms_i = 16'h0000;
  logic enc_pulse_i = 1'b0, enc_run = 1'b0;
  logic [2:0] enc_cnt = 3'h0;
  logic [31:0] dat_o, q;
  logic ack_o, relay_o, semi_q_o, semi_q_oe_o, settling_o, coil, q_pin;
  logic [15:0] rpm_o, r;
  int err_count = 0, samples_checked = 0, n;
  localparam logic [7:0] RA[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h1c, 8'h20};
  localparam logic [31:0] RV[6] = '{32'h0, 32'h0, 32'h3, 32'h1, 32'h0, 32'h0};
  localparam logic [15:0] ROWS[16] = '{
    16'h110c, 16'h1806, 16'h110c, 16'h0006, // energized-normal
    16'h300c, 16'h3906, 16'h2806, // energize-on-fault
    16'h910c, 16'h9406, 16'h9006, 16'h9306, // inflow
    16'h5006, 16'h5403, 16'h550c, 16'h5106, 16'h5206}; // drainage
  always #12.5 clk_i = ~clk_i;
  mosc_top #(.MS_CYC(4), .GATE_CYC(200)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
    .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .supply_ok_i(supply_ok_i),
    .fault_i(fault_i), .upper_over_i(upper_over_i), .lower_under_i(lower_under_i),
    .phase_loss_i(phase_loss_i), .manual_reset_i(manual_reset_i), .menu_exit_i(menu_exit_i),
    .mode_sel_i(mode_sel_i), .key_settle_we_i(key_settle_we_i),
    .key_settle_ms_i(key_settle_ms_i), .enc_pulse_i(enc_pulse_i), .relay_o(relay_o),
    .semi_q_o(semi_q_o), .semi_q_oe_o(semi_q_oe_o), .settling_o(settling_o), .rpm_o(rpm_o));
  mosc_load ld_u (.clk_i(clk_i), .relay_i(relay_o), .q_i(semi_q_o), .q_oe_i(semi_q_oe_o),
    .coil_o(coil), .q_pin_o(q_pin));
  // Encoder with a ten-cycle period: a whole number of edges in every gate
  always @(posedge clk_i)
    if (enc_run)
    begin
      enc_cnt <= (enc_cnt == 3'h4) ? 3'h0 : enc_cnt + 3'h1;
      if (enc_cnt == 3'h4) enc_pulse_i <= ~enc_pulse_i;
    end
  task automatic results();
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Classic cycle: ack read just after the edge is the value that edge sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    int k;
    k = 0;
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'h3;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && k < 20)
    begin
      @(posedge clk_i);
      k++;
    end
    // A request that is never answered counts against the run
    if (ack_o !== 1'b1) err_count++;
    rd = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_relay(input int lim, output int cnt);
    cnt = 0;
    while (relay_o !== 1'b1 && cnt < lim)
    begin
      @(posedge clk_i);
      cnt++;
    end
  endtask
  task automatic supply_cycle();
    supply_ok_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    supply_ok_i <= 1'b1;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    results();
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(relay_o), 32'h0);
    wb(1'b1, 8'h20, 32'hffff, q);
    for (int i = 0; i < 6; i++)
    begin
      wb(1'b0, RA[i], 32'h0, q);
      chk(q, RV[i]);
    end
    wb(1'b1, 8'h1c, 32'h2, q);
    for (int i = 0; i < 16; i++)
    begin
      r = ROWS[i];
      wb(1'b1, 8'h00, 32'(r[13]), q);
      mode_sel_i <= r[15:14]; supply_ok_i <= r[12]; fault_i <= r[11];
      upper_over_i <= r[10]; lower_under_i <= r[9];
      repeat (r[7:0]) @(posedge clk_i);
      chk(32'(relay_o), 32'(r[8]));
      if (r[15:14] == 2'h0) chk(32'(q_pin), 32'(r[8]));
      chk(32'(coil), 32'(r[8]));
    end
    mode_sel_i <= 2'h0; lower_under_i <= 1'b0;
    wb(1'b1, 8'h00, 32'h0, q);
    wb(1'b1, 8'h04, 32'h3, q);
    supply_cycle();
    wait_relay(60, n);
    chk(32'(n >= 12 && n <= 22), 32'h1);
    supply_cycle();
    repeat (6) @(posedge clk_i);
    fault_i <= 1'b1;
    @(posedge clk_i);
    fault_i <= 1'b0;
    wait_relay(60, n);
    chk(32'(n >= 12 && n <= 22), 32'h1);
    wb(1'b1, 8'h08, 32'h0, q);
    key_settle_ms_i <= 16'h0002; key_settle_we_i <= 1'b1;
    @(posedge clk_i);
    key_settle_we_i <= 1'b0;
    wb(1'b0, 8'h04, 32'h0, q);
    chk(q, 32'h2);
    wb(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h0);
    supply_cycle();
    wait_relay(60, n);
    chk(32'(n <= 6), 32'h1);
    wb(1'b1, 8'h08, 32'h3, q);
    wb(1'b1, 8'h04, 32'h1, q);
    wb(1'b1, 8'h00, 32'h4, q);
    fault_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    fault_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk(32'(relay_o), 32'h0);
    manual_reset_i <= 1'b1;
    @(posedge clk_i);
    manual_reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(32'(settling_o), 32'h1);
    wait_relay(40, n);
    chk(32'(relay_o), 32'h1);
    wb(1'b1, 8'h18, 32'h1, q);
    chk(32'(settling_o), 32'h1);
    wait_relay(40, n);
    chk(32'(relay_o), 32'h1);
    menu_exit_i <= 1'b1;
    @(posedge clk_i);
    menu_exit_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(32'(settling_o), 32'h1);
    wb(1'b1, 8'h0c, 32'h2, q);
    enc_run <= 1'b1;
    repeat (700) @(posedge clk_i);
    chk(32'(rpm_o), 32'h258);
    wb(1'b1, 8'h00, 32'h3, q);
    wb(1'b1, 8'h04, 32'ha, q);
    wb(1'b1, 8'h18, 32'h1, q);
    phase_loss_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(32'({relay_o, settling_o}), 32'h3);
    wb(1'b1, 8'h00, 32'h2, q);
    // Let settling run out so only the phase trip can hold the relay off
    repeat (50) @(posedge clk_i);
    chk(32'({relay_o, settling_o}), 32'h0);
    results();
  end
endmodule
`default_nettype wire
